/* File: rtl/eeprom_cmd_map.vh */
// constants for the serial eeprom command unit
`ifndef EEPROM_CMD_MAP_VH
`define EEPROM_CMD_MAP_VH
`define OP_READ 2'h1 << 1
`define OP_RD 2'h2
`define OP_WR 2'h1
`define OP_EXT 2'h0
`define EXT_ENABLE 2'h3
`define EXT_FILL 2'h1
`define EXT_DISABLE 2'h0
`define WORD_BITS 16
`define ADDR_BITS 7
`define CLK_HZ 40000000
`define PROG_TIME_MS 15
`define PROG_CYCLES ((`CLK_HZ / 1000) * `PROG_TIME_MS)
`endif

/* File: rtl/eeprom_cmd_unit.v */
// serial eeprom command decoder, shifter and self-timed program cycle
`timescale 1ns/1ps
`include "eeprom_cmd_map.vh"
module eeprom_cmd_unit #(
    parameter PROG_CYCLES = `PROG_CYCLES
) (
    input wire clk_in,
    input wire rst_in,
    input wire chip_select_in,
    input wire serial_shift_clock_in,
    input wire serial_data_in,
    input wire program_enable_pin_in,
    input wire protect_select_in,
    input wire protect_active_in,
    input wire [`ADDR_BITS-1:0] protect_addr_in,
    output reg serial_data_out,
    output reg serial_data_oe_n_out,
    output reg busy_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_OP = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_READ = 3'h4;
    localparam ST_ARMED = 3'h5;
    localparam ST_DONE = 3'h6;

    reg [2:0] state;
    reg [4:0] bit_cnt;
    reg [1:0] opcode;
    reg [7:0] addr;
    reg [`WORD_BITS-1:0] data_sr;
    reg [`WORD_BITS-1:0] out_sr;
    reg [6:0] rd_addr;
    reg prog_enabled;
    reg pe_latched;
    reg is_fill;
    reg cs_q;
    reg sk_q;
    reg status_mode;
    reg [31:0] prog_cnt;
    reg mem_write;
    reg mem_fill;
    reg buf_push;
    reg buf_pop;

    wire sk_rise;
    wire cs_fall;
    wire prog_start;
    wire [`WORD_BITS-1:0] mem_rdata;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [`WORD_BITS-1:0] buf_data;
    wire write_ok;
    wire fill_ok;
    wire [7:0] next_addr;

    // pins are sampled levels; edges are found against the previous sample
    assign sk_rise = serial_shift_clock_in && !sk_q;
    assign cs_fall = cs_q && !chip_select_in;
    // select falls right after a complete, allowed write or fill
    assign prog_start = cs_fall && (state == ST_ARMED) && !busy_out;
    assign next_addr = {addr[6:0], serial_data_in};
    // a single write needs a word below the first protected address
    assign write_ok = prog_enabled && pe_latched
        && (!protect_active_in || addr[6:0] < protect_addr_in);
    assign fill_ok = prog_enabled && pe_latched && !protect_active_in;

    word_array #(
        .WIDTH(`WORD_BITS),
        .ABITS(`ADDR_BITS)
    ) u_array (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .write_in(mem_write),
        .fill_in(mem_fill),
        .waddr_in(addr[6:0]),
        .wdata_in(data_sr),
        .raddr_in(rd_addr),
        .rdata_out(mem_rdata)
    );

    // the buffer is emptied whenever select is low
    word_buffer #(
        .WIDTH(`WORD_BITS)
    ) u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .flush_in(!chip_select_in),
        .in_valid_in(buf_push),
        .in_ready_out(buf_in_ready),
        .in_data_in(mem_rdata),
        .out_valid_out(buf_out_valid),
        .out_ready_in(buf_pop),
        .out_data_out(buf_data)
    );

    // last sampled levels of select and shift clock; reset matches the idle pins
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cs_q <= 1'b0;
            sk_q <= 1'b0;
        end
        else
        begin
            cs_q <= chip_select_in;
            sk_q <= serial_shift_clock_in;
        end
    end

    // ready/busy display, kept over select cycles while busy; ends at a start bit or a select fall after ready
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            status_mode <= 1'b0;
        else if (prog_start)
            status_mode <= 1'b1;
        else if (cs_fall && !busy_out)
            status_mode <= 1'b0;
        // a start bit after ready hands the pin back to the command shifter
        else if (chip_select_in && sk_rise && serial_data_in && !busy_out)
            status_mode <= 1'b0;
    end

    // self-timed program cycle; runs on whatever select does
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            busy_out <= 1'b0;
            prog_cnt <= 32'h0000_0000;
            mem_write <= 1'b0;
            mem_fill <= 1'b0;
        end
        else
        begin
            mem_write <= 1'b0;
            mem_fill <= 1'b0;
            if (prog_start)
            begin
                busy_out <= 1'b1;
                prog_cnt <= PROG_CYCLES - 1;
            end
            else if (busy_out)
            begin
                // the word lands one cycle after busy drops, long before a read can reach it
                if (prog_cnt == 32'h0000_0000)
                begin
                    busy_out <= 1'b0;
                    if (is_fill)
                        mem_fill <= 1'b1;
                    else
                        mem_write <= 1'b1;
                end
                else
                    prog_cnt <= prog_cnt - 32'h0000_0001;
            end
        end
    end

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            bit_cnt <= 5'h0;
            opcode <= 2'h0;
            addr <= 8'h00;
            data_sr <= 16'h0000;
            out_sr <= 16'h0000;
            rd_addr <= 7'h00;
            prog_enabled <= 1'b0;
            pe_latched <= 1'b0;
            is_fill <= 1'b0;
            buf_push <= 1'b0;
            buf_pop <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe_n_out <= 1'b1;
        end
        else
        begin
            buf_push <= 1'b0;
            buf_pop <= 1'b0;
            if (!chip_select_in)
            begin
                // select low clears command state and releases the output
                state <= ST_IDLE;
                bit_cnt <= 5'h0;
                serial_data_oe_n_out <= 1'b1;
                serial_data_out <= 1'b0;
            end
            else if (status_mode)
            begin
                // ready/busy on the data output until a new start bit
                serial_data_oe_n_out <= 1'b0;
                serial_data_out <= !busy_out;
                if (sk_rise && serial_data_in && !busy_out)
                begin
                    state <= ST_OP;
                    bit_cnt <= 5'h0;
                end
            end
            else if (sk_rise)
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (serial_data_in && !busy_out)
                        begin
                            state <= ST_OP;
                            bit_cnt <= 5'h0;
                        end
                    end
                    ST_OP:
                    begin
                        opcode <= {opcode[0], serial_data_in};
                        bit_cnt <= bit_cnt + 5'h1;
                        if (bit_cnt == 5'h1)
                        begin
                            state <= ST_ADDR;
                            bit_cnt <= 5'h0;
                        end
                    end
                    ST_ADDR:
                    begin
                        addr <= next_addr;
                        bit_cnt <= bit_cnt + 5'h1;
                        if (bit_cnt == 5'h7)
                        begin
                            bit_cnt <= 5'h0;
                            pe_latched <= program_enable_pin_in;
                            if (protect_select_in)
                                state <= ST_DONE;
                            else if (opcode == `OP_RD)
                            begin
                                state <= ST_READ;
                                rd_addr <= next_addr[6:0];
                                buf_push <= 1'b1;
                                serial_data_oe_n_out <= 1'b0;
                                serial_data_out <= 1'b0;
                            end
                            else if (opcode == `OP_WR)
                            begin
                                state <= ST_DATA;
                                is_fill <= 1'b0;
                            end
                            else if (opcode == `OP_EXT && next_addr[7:6] == `EXT_FILL)
                            begin
                                state <= ST_DATA;
                                is_fill <= 1'b1;
                            end
                            else if (opcode == `OP_EXT && next_addr[7:6] == `EXT_ENABLE)
                            begin
                                // an enable with the pin low leaves the current setting alone
                                if (program_enable_pin_in)
                                    prog_enabled <= 1'b1;
                                state <= ST_DONE;
                            end
                            else if (opcode == `OP_EXT && next_addr[7:6] == `EXT_DISABLE)
                            begin
                                prog_enabled <= 1'b0;
                                state <= ST_DONE;
                            end
                            else
                                state <= ST_DONE;
                        end
                    end
                    ST_DATA:
                    begin
                        data_sr <= {data_sr[14:0], serial_data_in};
                        bit_cnt <= bit_cnt + 5'h1;
                        if (bit_cnt == 5'hf)
                        begin
                            // armed only if allowed; the select fall then starts it
                            if (is_fill ? fill_ok : write_ok)
                                state <= ST_ARMED;
                            else
                                state <= ST_DONE;
                        end
                    end
                    ST_READ:
                    begin
                        serial_data_oe_n_out <= 1'b0;
                        if (bit_cnt == 5'h0)
                        begin
                            // take the next word from the buffer, prefetch the one after
                            out_sr <= {buf_data[14:0], 1'b0};
                            serial_data_out <= buf_data[15];
                            buf_pop <= buf_out_valid;
                            rd_addr <= rd_addr + 7'h1;
                            buf_push <= buf_in_ready;
                            bit_cnt <= 5'h1;
                        end
                        else
                        begin
                            serial_data_out <= out_sr[15];
                            out_sr <= {out_sr[14:0], 1'b0};
                            bit_cnt <= (bit_cnt == 5'hf) ? 5'h0 : bit_cnt + 5'h1;
                        end
                    end
                    ST_ARMED:
                    begin
                        // an extra clock before select falls cancels the write
                        state <= ST_DONE;
                    end
                    ST_DONE:
                    begin
                        state <= ST_DONE;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // eeprom_cmd_unit

/* File: rtl/word_array.v */
// 128 x 16 flip-flop word storage with single write and fill-all
`timescale 1ns/1ps
module word_array #(
    parameter WIDTH = 16,
    parameter ABITS = 7
) (
    input wire clk_in,
    input wire rst_in,
    input wire write_in,
    input wire fill_in,
    input wire [ABITS-1:0] waddr_in,
    input wire [WIDTH-1:0] wdata_in,
    input wire [ABITS-1:0] raddr_in,
    output wire [WIDTH-1:0] rdata_out
);
    localparam DEPTH = 1 << ABITS;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    assign rdata_out = mem[raddr_in];
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : g_word
            localparam [ABITS-1:0] IDX = i;
            always @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                    mem[i] <= {WIDTH{1'b1}};
                else if (fill_in || (write_in && waddr_in == IDX))
                    mem[i] <= wdata_in;
            end
        end
    endgenerate
endmodule // word_array

/* File: rtl/word_buffer.v */
// two-entry valid/ready buffer for words leaving the memory array
`timescale 1ns/1ps
module word_buffer #(
    parameter WIDTH = 16
) (
    input wire clk_in,
    input wire rst_in,
    input wire flush_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] slot [0:1];
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire push;
    wire pop;
    assign in_ready_out = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out = slot[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
            slot[0] <= {WIDTH{1'b0}};
            slot[1] <= {WIDTH{1'b0}};
        end
        else if (flush_in)
        begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                slot[wr_ptr] <= in_data_in;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // word_buffer

/* File: sim/eeprom_cmd_checker.sv */
// port assertions for the serial eeprom command unit
`timescale 1ns/1ps
module eeprom_cmd_checker #(
    parameter PROG_CYCLES = 20
) (
    input wire clk_in,
    input wire rst_in,
    input wire chip_select_in,
    input wire serial_shift_clock_in,
    input wire serial_data_in,
    input wire program_enable_pin_in,
    input wire protect_select_in,
    input wire protect_active_in,
    input wire [6:0] protect_addr_in,
    input wire serial_data_out,
    input wire serial_data_oe_n_out,
    input wire busy_out
);
    int busy_cnt;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // length of the current program cycle
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            busy_cnt <= 0;
        else if (busy_out)
            busy_cnt <= busy_cnt + 1;
        else
            busy_cnt <= 0;
    end
    property p_out_on_rise;
        $changed(serial_data_out) && chip_select_in && $past(chip_select_in, 3)
            && !$past(busy_out, 3) |-> $past(serial_shift_clock_in)
            && !$past(serial_shift_clock_in, 2);
    endproperty
    a_out_on_rise: assert property (p_out_on_rise) else $error("output moved without clock");
    property p_dummy_zero;
        $fell(serial_data_oe_n_out) && $past(chip_select_in, 4) |-> !serial_data_out;
    endproperty
    a_dummy_zero: assert property (p_dummy_zero) else $error("first read bit not zero");
    property p_release;
        !$past(chip_select_in, 2) && !$past(chip_select_in) |-> serial_data_oe_n_out;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected");
    property p_release_cause;
        $rose(serial_data_oe_n_out) |-> !$past(chip_select_in) || !$past(chip_select_in, 2);
    endproperty
    a_release_cause: assert property (p_release_cause) else $error("output released early");
    property p_busy_start;
        $rose(busy_out) |-> !$past(chip_select_in)
            && ($past(chip_select_in, 2) || $past(chip_select_in, 3));
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without select fall");
    property p_busy_len;
        $fell(busy_out) |-> busy_cnt == PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("program cycle length wrong");
    property p_status_busy;
        chip_select_in && $past(chip_select_in, 3) && busy_out && $past(busy_out, 3)
            |-> !serial_data_out && !serial_data_oe_n_out;
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("busy status not zero");
    property p_status_ready;
        $fell(busy_out) && chip_select_in |-> ##[0:2] (serial_data_out && !serial_data_oe_n_out);
    endproperty
    a_status_ready: assert property (p_status_ready) else $error("ready status missing");
endmodule // eeprom_cmd_checker
bind eeprom_cmd_unit eeprom_cmd_checker #(.PROG_CYCLES(PROG_CYCLES)) i_eeprom_cmd_checker (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .chip_select_in(chip_select_in),
    .serial_shift_clock_in(serial_shift_clock_in),
    .serial_data_in(serial_data_in),
    .program_enable_pin_in(program_enable_pin_in),
    .protect_select_in(protect_select_in),
    .protect_active_in(protect_active_in),
    .protect_addr_in(protect_addr_in),
    .serial_data_out(serial_data_out),
    .serial_data_oe_n_out(serial_data_oe_n_out),
    .busy_out(busy_out)
);

/* File: sim/host_model.sv */
// host controller driving the three-wire command interface
`timescale 1ns/1ps
module host_model (
    input wire clk_in,
    input wire sdo_in,
    output reg cs_out,
    output reg sck_out,
    output reg sdi_out,
    output reg pe_out,
    output reg pre_out
);
    int slow = 0;
    initial
    begin
        cs_out = 1'h0;
        sck_out = 1'h0;
        sdi_out = 1'h0;
        pe_out = 1'h1;
        pre_out = 1'h0;
    end
    // data set while the clock is low; output taken just before the fall
    task automatic clock_bit(input logic b, output logic got);
    begin
        sdi_out = b;
        repeat (2) @(negedge clk_in);
        sck_out = 1'h1;
        repeat (3 + slow) @(negedge clk_in);
        got = sdo_in;
        sck_out = 1'h0;
        repeat (2) @(negedge clk_in);
    end
    endtask
    task automatic shift(input int n, input logic [26:0] bits, output logic [15:0] got);
        logic g;
    begin
        got = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            clock_bit(bits[i], g);
            got = {got[14:0], g};
        end
    end
    endtask
    task automatic open_frame;
    begin
        cs_out = 1'h1;
        repeat (4) @(negedge clk_in);
    end
    endtask
    // select drops right after the last bit; data line no longer holds its value
    task automatic close_frame;
    begin
        cs_out = 1'h0;
        sdi_out = ~sdi_out;
        repeat (4) @(negedge clk_in);
    end
    endtask
endmodule // host_model

/* File: sim/tb_top.sv */
// self-checking bench for the serial eeprom command unit
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        n_tests++; \
        if ((a) !== (b)) \
        begin \
            error_cnt++; \
            $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); \
        end \
    end
module tb_top;
    logic clk, rst, cs, sck, sdi, pe, pre, prot_act, sdo, oe_n, busy;
    logic [6:0] prot_addr;
    logic [15:0] g;
    int error_cnt = 0;
    int n_tests = 0;
    // write address, write data, read address, expected word
    logic [47:0] rows [5] = '{48'h0512_3405_1234, 48'h85a5_c305_a5c3, 48'h7f00_017f_0001,
                              48'h0080_0000_8000, 48'h3aff_feba_fffe};
    eeprom_cmd_unit #(.PROG_CYCLES(20)) i_eeprom_cmd_unit (
        .clk_in(clk), .rst_in(rst), .chip_select_in(cs), .serial_shift_clock_in(sck),
        .serial_data_in(sdi), .program_enable_pin_in(pe), .protect_select_in(pre),
        .protect_active_in(prot_act), .protect_addr_in(prot_addr), .serial_data_out(sdo),
        .serial_data_oe_n_out(oe_n), .busy_out(busy));
    // a released data line reads high at the host, as with a pull-up
    host_model i_host_model (.clk_in(clk), .sdo_in(oe_n ? 1'h1 : sdo), .cs_out(cs),
        .sck_out(sck), .sdi_out(sdi), .pe_out(pe), .pre_out(pre));
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic print_verdict;
    begin
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d, bit wd);
    begin
        i_host_model.open_frame();
        if (wd)
            i_host_model.shift(27, {1'h1, op, a, d}, g);
        else
            i_host_model.shift(11, {16'h0000, 1'h1, op, a}, g);
        i_host_model.close_frame();
    end
    endtask
    // raise select during the program cycle and follow the status bit
    task automatic prog_check(input logic exp_busy);
        int k;
    begin
        `CHK(busy, exp_busy)
        if (exp_busy)
        begin
            i_host_model.open_frame();
            `CHK({sdo, oe_n}, 2'h0)
            // status must come back on a second select cycle while still busy
            i_host_model.close_frame();
            i_host_model.open_frame();
            `CHK({sdo, oe_n, busy}, 3'h1)
            k = 0;
            while (busy === 1'h1 && k < 100)
            begin
                @(negedge clk);
                k++;
            end
            repeat (3) @(negedge clk);
            `CHK({sdo, oe_n, busy}, 3'h4)
            i_host_model.close_frame();
        end
    end
    endtask
    task automatic rd(input logic [7:0] a, input int n, input logic [15:0] e0, e1);
    begin
        i_host_model.open_frame();
        i_host_model.shift(11, {16'h0000, 3'h6, a}, g);
        `CHK({g[0], oe_n}, 2'h0)
        i_host_model.shift(16, 27'h000_0000, g);
        `CHK(g, e0)
        if (n > 1)
        begin
            i_host_model.shift(16, 27'h000_0000, g);
            `CHK(g, e1)
        end
        i_host_model.close_frame();
    end
    endtask
    initial
    begin
        #(80000 * 25);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        rst = 1'h1;
        prot_act = 1'h0;
        prot_addr = 7'h7f;
        repeat (12) @(negedge clk);
        rst = 1'h0;
        repeat (2) @(negedge clk);
        `CHK({busy, oe_n}, 2'h1)
        cmd(2'h1, 8'h10, 16'h1234, 1);
        prog_check(1'h0);
        rd(8'h10, 1, 16'hffff, 16'h0000);
        cmd(2'h0, 8'hc0, 16'h0000, 0);
        foreach (rows[i])
        begin
            cmd(2'h1, rows[i][47:40], rows[i][39:24], 1);
            prog_check(1'h1);
            rd(rows[i][23:16], 1, rows[i][15:0], 16'h0000);
        end
        rd(8'h7f, 2, 16'h0001, 16'h8000);
        i_host_model.pe_out = 1'h0;
        // an enable with the pin low must not turn programming off
        cmd(2'h0, 8'hc0, 16'h0000, 0);
        cmd(2'h1, 8'h20, 16'h5555, 1);
        i_host_model.pe_out = 1'h1;
        prog_check(1'h0);
        i_host_model.pre_out = 1'h1;
        cmd(2'h1, 8'h21, 16'h5555, 1);
        i_host_model.pre_out = 1'h0;
        prog_check(1'h0);
        prot_act = 1'h1;
        prot_addr = 7'h40;
        cmd(2'h1, 8'h40, 16'h5555, 1);
        prog_check(1'h0);
        cmd(2'h1, 8'h3f, 16'h0f0f, 1);
        prog_check(1'h1);
        cmd(2'h0, 8'h40, 16'hbeef, 1);
        prog_check(1'h0);
        prot_act = 1'h0;
        cmd(2'h0, 8'h40, 16'hbeef, 1);
        prog_check(1'h1);
        i_host_model.slow = 3;
        rd(8'h7f, 2, 16'hbeef, 16'hbeef);
        i_host_model.slow = 0;
        cmd(2'h0, 8'h00, 16'h0000, 0);
        cmd(2'h1, 8'h05, 16'h1111, 1);
        prog_check(1'h0);
        rd(8'h05, 1, 16'hbeef, 16'h0000);
        i_host_model.open_frame();
        i_host_model.shift(5, 27'h000_001a, g);
        i_host_model.close_frame();
        rd(8'h05, 1, 16'hbeef, 16'h0000);
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (2) @(negedge clk);
        cmd(2'h1, 8'h05, 16'h1111, 1);
        prog_check(1'h0);
        rd(8'h05, 1, 16'hffff, 16'h0000);
        print_verdict();
    end
endmodule // tb_top
